// ### pm_event_regs.vh
/*
 * Constants for the power-management event block: I/O ports of the
 * index/data pair, register indices, field positions and reset values.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PM_EVENT_REGS_VH
`define PM_EVENT_REGS_VH

// I/O ports of the index/data pair
`define PM_INDEX_PORT 16'h0022
`define PM_DATA_PORT 16'h0023

// Register indices
`define IDX_MISC_EN 8'h90
`define IDX_CARD_KBD_EN 8'h91
`define IDX_TIMER_EN 8'h92
`define IDX_EDGE_EN 8'h93
`define IDX_MISC_ST 8'h94
`define IDX_CARD_KBD_ST 8'h95
`define IDX_TIMER_ST 8'h96
`define IDX_EDGE_ST 8'h97
`define IDX_ROUTE_SEL 8'h98

// Reset values
`define RST_BYTE 8'h00
`define RST_TIMER 5'h00
`define RST_TIMER_ST 6'h00
`define RST_MISC_EN 6'h00

// Miscellaneous enable / status fields
`define MISC_WAKE 7
`define MISC_SERIAL_RX 6
`define MISC_RING 5
`define MISC_ALARM 4
`define MISC_SUSP_RISE 3
`define MISC_SUSP_FALL 2
`define MISC_FORCE_NMI 1
`define MISC_FORCE_SMI 0

// Card / keyboard field: key press or XT byte
`define CK_KEY_PRESS 4

// Timer status field of the general-purpose pin event
`define TM_GP_PIN 5

// Route select fields (0 = SMI, 1 = NMI)
`define SEL_ALARM 7
`define SEL_UART 6
`define SEL_CARD 5
`define SEL_WAKE 4
`define SEL_KBD 3
`define SEL_SUSP 2
`define SEL_BATT 1
`define SEL_TIMER 0

// Pin slots of the synchroniser and edge unit
`define PIN_BL0 0
`define PIN_BL1 1
`define PIN_BL2 2
`define PIN_AC 3
`define PIN_SUSP 4
`define PIN_SIN 5
`define PIN_RIN 6

`endif

// ### pin_sync.v
/*
 * Three-stage input synchroniser for a group of pins.
 * Assumes asynchronous pins; the filtered level changes once stages two
 * and three agree.
 */
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Pins and filtered levels
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer i;

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            level_out <= {WIDTH{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ### edge_event_unit.v
/*
 * Edge event detector with enable-time level check.
 * An event fires when (enable and post-edge level) goes from false to true,
 * so a real edge while enabled and enabling while already at the post-edge
 * level both fire once. Assumes synchronised levels on the same clock.
 */
`timescale 1ns/10ps
module edge_event_unit #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Levels and enables
    input wire [WIDTH-1:0] level_in,
    input wire [WIDTH-1:0] rise_en_in,
    input wire [WIDTH-1:0] fall_en_in,
    // One-cycle event pulses
    output wire [WIDTH-1:0] rise_evt_out,
    output wire [WIDTH-1:0] fall_evt_out
);
    wire [WIDTH-1:0] rise_cond;
    wire [WIDTH-1:0] fall_cond;
    reg [WIDTH-1:0] rise_prev_q;
    reg [WIDTH-1:0] fall_prev_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : slot
            assign rise_cond[g] = rise_en_in[g] & level_in[g];
            assign fall_cond[g] = fall_en_in[g] & ~level_in[g];
            assign rise_evt_out[g] = rise_cond[g] & ~rise_prev_q[g];
            assign fall_evt_out[g] = fall_cond[g] & ~fall_prev_q[g];
        end
    endgenerate

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rise_prev_q <= {WIDTH{1'b0}};
            fall_prev_q <= {WIDTH{1'b0}};
        end else begin
            rise_prev_q <= rise_cond;
            fall_prev_q <= fall_cond;
        end
    end
endmodule

// ### pm_event_ctrl.v
/*
 * Power-management event collector: enables, sticky status and routing of
 * many event sources onto SMI and NMI requests, reached through an
 * index/data I/O port pair.
 * Assumes on-chip event inputs are one-cycle pulses on clk_in and that the
 * battery, AC, suspend/resume, serial input and ring pins are asynchronous.
 */

`timescale 1ns/10ps
`include "pm_event_regs.vh"
module pm_event_ctrl #(
    parameter ADDR_WIDTH = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // I/O port access
    input wire [ADDR_WIDTH-1:0] io_addr_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire [7:0] io_wdata_in,
    output reg [7:0] io_rdata_out,
    // Asynchronous pins
    input wire ac_power_present_in,
    input wire battery_low_zero_in,
    input wire battery_low_one_in,
    input wire battery_low_two_in,
    input wire suspend_resume_pin_in,
    input wire serial_rx_pin_in,
    input wire ring_ind_pin_in,
    // On-chip event pulses
    input wire wakeup_evt_in,
    input wire alarm_evt_in,
    input wire [7:0] card_kbd_evt_in,
    input wire [4:0] timer_evt_in,
    input wire gp_pin_evt_in,
    // XT keyboard mode and its control bit
    input wire xt_mode_in,
    input wire xt_ctl_bit_in,
    // Requests to the core
    output reg smi_req_out,
    output reg nmi_req_out
);
    localparam PAIRS = 4;
    localparam PINS = 7;

    reg [7:0] index_q;
    reg [7:2] misc_en_q;
    reg [7:0] card_kbd_en_q;
    reg [4:0] timer_en_q;
    reg [7:0] edge_en_q;
    reg [7:0] misc_st_q;
    reg [7:0] misc_st_d;
    reg [7:0] card_kbd_st_q;
    reg [7:0] card_kbd_st_d;
    reg [5:0] timer_st_q;
    reg [5:0] timer_st_d;
    reg [7:0] edge_st_q;
    reg [7:0] edge_st_d;
    reg [7:0] route_sel_q;
    reg xt_hold_q;
    reg xt_ctl_prev_q;
    reg [7:0] rd_mux;
    reg [7:0] group_req;

    wire data_wr = io_wr_in & (io_addr_in == `PM_DATA_PORT);
    wire index_wr = io_wr_in & (io_addr_in == `PM_INDEX_PORT);
    wire [PINS-1:0] pin_level;
    wire [PINS-1:0] pin_rise_en;
    wire [PINS-1:0] pin_fall_en;
    wire [PINS-1:0] pin_rise;
    wire [PINS-1:0] pin_fall;
    wire [7:0] edge_set;
    wire [7:0] edge_clr;
    wire [7:0] misc_set;
    wire [7:0] card_kbd_set;
    wire [5:0] timer_set;

    // Write strobe for one register index
    function hit;
        input wr;
        input [7:0] cur_idx;
        input [7:0] idx;
        begin
            hit = wr & (cur_idx == idx);
        end
    endfunction

    pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in({ring_ind_pin_in, serial_rx_pin_in, suspend_resume_pin_in,
                 ac_power_present_in, battery_low_two_in,
                 battery_low_one_in, battery_low_zero_in}),
        .level_out(pin_level)
    );

    genvar p;
    generate
        for (p = 0; p < PAIRS; p = p + 1) begin : pair
            assign pin_rise_en[p] = edge_en_q[2*p+1];
            assign pin_fall_en[p] = edge_en_q[2*p];
            assign edge_set[2*p+1] = pin_rise[p];
            assign edge_set[2*p] = pin_fall[p];
            // Pair clears only when both bits are written as zero
            assign edge_clr[2*p+1] = ~io_wdata_in[2*p+1] &
                ~io_wdata_in[2*p];
            assign edge_clr[2*p] = edge_clr[2*p+1];
        end
    endgenerate

    assign pin_rise_en[`PIN_SUSP] = misc_en_q[`MISC_SUSP_RISE];
    assign pin_fall_en[`PIN_SUSP] = misc_en_q[`MISC_SUSP_FALL];
    assign pin_rise_en[`PIN_SIN] = 1'b0;
    assign pin_fall_en[`PIN_SIN] = misc_en_q[`MISC_SERIAL_RX];
    assign pin_rise_en[`PIN_RIN] = 1'b0;
    assign pin_fall_en[`PIN_RIN] = misc_en_q[`MISC_RING];

    edge_event_unit #(
        .WIDTH(PINS)
    ) u_edge (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .level_in(pin_level),
        .rise_en_in(pin_rise_en),
        .fall_en_in(pin_fall_en),
        .rise_evt_out(pin_rise),
        .fall_evt_out(pin_fall)
    );

    // Sources gated by their enables, except the force bits and the general-purpose pin event
    assign misc_set = {
        wakeup_evt_in & misc_en_q[`MISC_WAKE],
        pin_fall[`PIN_SIN],
        pin_fall[`PIN_RIN],
        alarm_evt_in & misc_en_q[`MISC_ALARM],
        pin_rise[`PIN_SUSP],
        pin_fall[`PIN_SUSP],
        hit(data_wr, index_q, `IDX_MISC_EN) &
            io_wdata_in[`MISC_FORCE_NMI],
        hit(data_wr, index_q, `IDX_MISC_EN) &
            io_wdata_in[`MISC_FORCE_SMI]
    };
    assign card_kbd_set = card_kbd_evt_in & card_kbd_en_q;
    assign timer_set = {gp_pin_evt_in,
                        timer_evt_in & timer_en_q};

    // Status next values: a set in the clearing cycle wins
    always @* begin
        misc_st_d = misc_st_q;
        card_kbd_st_d = card_kbd_st_q;
        timer_st_d = timer_st_q;
        edge_st_d = edge_st_q;
        if (hit(data_wr, index_q, `IDX_MISC_ST)) begin
            misc_st_d = misc_st_q & io_wdata_in;
            // Suspend pin pair clears only on 00b
            misc_st_d[`MISC_SUSP_RISE] = misc_st_q[`MISC_SUSP_RISE] &
                (io_wdata_in[`MISC_SUSP_RISE] |
                 io_wdata_in[`MISC_SUSP_FALL]);
            misc_st_d[`MISC_SUSP_FALL] = misc_st_q[`MISC_SUSP_FALL] &
                (io_wdata_in[`MISC_SUSP_RISE] |
                 io_wdata_in[`MISC_SUSP_FALL]);
        end
        if (hit(data_wr, index_q, `IDX_CARD_KBD_ST)) begin
            card_kbd_st_d = card_kbd_st_q & io_wdata_in;
        end
        if (hit(data_wr, index_q, `IDX_TIMER_ST)) begin
            timer_st_d = timer_st_q & io_wdata_in[5:0];
        end
        if (hit(data_wr, index_q, `IDX_EDGE_ST)) begin
            edge_st_d = edge_st_q & ~edge_clr;
        end
        misc_st_d = misc_st_d | misc_set;
        card_kbd_st_d = card_kbd_st_d | card_kbd_set;
        timer_st_d = timer_st_d | timer_set;
        edge_st_d = edge_st_d | edge_set;
    end

    // Register file and status flip-flops
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            index_q <= `RST_BYTE;
            misc_en_q <= `RST_MISC_EN;
            card_kbd_en_q <= `RST_BYTE;
            timer_en_q <= `RST_TIMER;
            edge_en_q <= `RST_BYTE;
            misc_st_q <= `RST_BYTE;
            card_kbd_st_q <= `RST_BYTE;
            timer_st_q <= `RST_TIMER_ST;
            edge_st_q <= `RST_BYTE;
            route_sel_q <= `RST_BYTE;
        end else begin
            if (index_wr) begin
                index_q <= io_wdata_in;
            end
            if (hit(data_wr, index_q, `IDX_MISC_EN)) begin
                misc_en_q <= io_wdata_in[7:2];
            end
            if (hit(data_wr, index_q, `IDX_CARD_KBD_EN)) begin
                card_kbd_en_q <= io_wdata_in;
            end
            if (hit(data_wr, index_q, `IDX_TIMER_EN)) begin
                timer_en_q <= io_wdata_in[4:0];
            end
            if (hit(data_wr, index_q, `IDX_EDGE_EN)) begin
                edge_en_q <= io_wdata_in;
            end
            if (hit(data_wr, index_q, `IDX_ROUTE_SEL)) begin
                route_sel_q <= io_wdata_in;
            end
            misc_st_q <= misc_st_d;
            card_kbd_st_q <= card_kbd_st_d;
            timer_st_q <= timer_st_d;
            edge_st_q <= edge_st_d;
        end
    end

    // XT keyboard events stay pending until the control bit toggles
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            xt_hold_q <= 1'b0;
            xt_ctl_prev_q <= 1'b0;
        end else begin
            xt_ctl_prev_q <= xt_ctl_bit_in;
            if (xt_mode_in & card_kbd_set[`CK_KEY_PRESS]) begin
                xt_hold_q <= 1'b1;
            end else if (xt_ctl_bit_in != xt_ctl_prev_q) begin
                xt_hold_q <= 1'b0;
            end
        end
    end

    // Read data; force bits of the enable register and reserved bits read as zero
    always @* begin
        case (index_q)
            `IDX_MISC_EN: rd_mux = {misc_en_q, 2'b00};
            `IDX_CARD_KBD_EN: rd_mux = card_kbd_en_q;
            `IDX_TIMER_EN: rd_mux = {3'b000, timer_en_q};
            `IDX_EDGE_EN: rd_mux = edge_en_q;
            `IDX_MISC_ST: rd_mux = misc_st_q;
            `IDX_CARD_KBD_ST: rd_mux = card_kbd_st_q;
            `IDX_TIMER_ST: rd_mux = {2'b00, timer_st_q};
            `IDX_EDGE_ST: rd_mux = edge_st_q;
            `IDX_ROUTE_SEL: rd_mux = route_sel_q;
            default: rd_mux = `RST_BYTE;
        endcase
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            io_rdata_out <= `RST_BYTE;
        end else if (io_rd_in & (io_addr_in == `PM_INDEX_PORT)) begin
            io_rdata_out <= index_q;
        end else if (io_rd_in & (io_addr_in == `PM_DATA_PORT)) begin
            io_rdata_out <= rd_mux;
        end
    end

    // Group requests, held while any status bit other than the force bits stays set
    always @* begin
        group_req = `RST_BYTE;
        group_req[`SEL_ALARM] = misc_st_q[`MISC_ALARM];
        group_req[`SEL_UART] = misc_st_q[`MISC_SERIAL_RX] |
            misc_st_q[`MISC_RING];
        group_req[`SEL_CARD] = |card_kbd_st_q[3:0];
        group_req[`SEL_WAKE] = misc_st_q[`MISC_WAKE];
        group_req[`SEL_KBD] = (|card_kbd_st_q[7:4]) | xt_hold_q;
        group_req[`SEL_SUSP] = misc_st_q[`MISC_SUSP_RISE] |
            misc_st_q[`MISC_SUSP_FALL];
        group_req[`SEL_BATT] = |edge_st_q;
        group_req[`SEL_TIMER] = |timer_st_q;
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            smi_req_out <= 1'b0;
            nmi_req_out <= 1'b0;
        end else begin
            smi_req_out <= (|(group_req & ~route_sel_q)) |
                misc_st_q[`MISC_FORCE_SMI];
            nmi_req_out <= (|(group_req & route_sel_q)) |
                misc_st_q[`MISC_FORCE_NMI];
        end
    end
endmodule

// ### core_model.sv
/* Model of the core's request inputs: counts entries on SMI and NMI.
   Assumes the requests are levels on clk_in. */
`timescale 1ns/10ps
module core_model (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Requests from the event block
    input wire smi_req_in,
    input wire nmi_req_in,
    // Entry counts
    output reg [7:0] smi_entries_out,
    output reg [7:0] nmi_entries_out
);
    reg smi_seen_q;
    reg nmi_seen_q;
    // A held request is one entry; only a fresh rise counts again
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            smi_seen_q <= 1'b0;
            nmi_seen_q <= 1'b0;
            smi_entries_out <= 8'h00;
            nmi_entries_out <= 8'h00;
        end else begin
            smi_seen_q <= smi_req_in;
            nmi_seen_q <= nmi_req_in;
            if (smi_req_in && !smi_seen_q)
                smi_entries_out <= smi_entries_out + 8'h01;
            if (nmi_req_in && !nmi_seen_q)
                nmi_entries_out <= nmi_entries_out + 8'h01;
        end
    end
endmodule

// ### pm_event_ctrl_asserts.sv
/* Checker for pm_event_ctrl: shadows enable writes, checks routing,
   read-back and hold timing. Sees only the block's ports. */
`timescale 1ns/10ps
module pm_event_checker #(
    parameter ADDR_WIDTH = 16
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [ADDR_WIDTH-1:0] io_addr_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire [7:0] io_wdata_in,
    input wire [7:0] io_rdata_out,
    input wire wakeup_evt_in,
    input wire [4:0] timer_evt_in,
    input wire xt_ctl_bit_in,
    input wire smi_req_out,
    input wire nmi_req_out
);
    reg [7:0] idx_q;
    reg [7:0] edge_en_q;
    reg [7:0] sel_q;
    reg [4:0] tmr_en_q;
    reg wake_en_q;
    wire dwr = io_wr_in && io_addr_in == 16'h0023;
    wire drd = io_rd_in && io_addr_in == 16'h0023;
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            idx_q <= 8'h00;
            edge_en_q <= 8'h00;
            sel_q <= 8'h00;
            tmr_en_q <= 5'h00;
            wake_en_q <= 1'b0;
        end else begin
            if (io_wr_in && io_addr_in == 16'h0022)
                idx_q <= io_wdata_in;
            if (dwr && idx_q == 8'h90)
                wake_en_q <= io_wdata_in[7];
            if (dwr && idx_q == 8'h92)
                tmr_en_q <= io_wdata_in[4:0];
            if (dwr && idx_q == 8'h93)
                edge_en_q <= io_wdata_in;
            if (dwr && idx_q == 8'h98)
                sel_q <= io_wdata_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_wake_route: assert property (
        wakeup_evt_in && wake_en_q |->
        ##[2:3] (sel_q[4] ? nmi_req_out : smi_req_out))
        else $error("wake event gave no request");
    a_timer_route: assert property (
        |(timer_evt_in & tmr_en_q) |->
        ##[2:3] (sel_q[0] ? nmi_req_out : smi_req_out))
        else $error("timer event gave no request");
    a_force_smi: assert property (
        dwr && idx_q == 8'h90 && io_wdata_in[0] |-> ##[1:3] smi_req_out)
        else $error("forced smi missing");
    a_force_nmi: assert property (
        dwr && idx_q == 8'h90 && io_wdata_in[1] |-> ##[1:3] nmi_req_out)
        else $error("forced nmi missing");
    a_timer_en_read: assert property (
        drd && idx_q == 8'h92 |=> io_rdata_out == {3'b000, tmr_en_q})
        else $error("timer enable read-back wrong");
    a_edge_en_read: assert property (
        drd && idx_q == 8'h93 |=> io_rdata_out == edge_en_q)
        else $error("edge enable read-back wrong");
    a_unmapped_zero: assert property (
        drd && (idx_q < 8'h90 || idx_q > 8'h98) |=> io_rdata_out == 8'h00)
        else $error("unmapped index not zero");
    a_rdata_hold: assert property (
        !io_rd_in |=> $stable(io_rdata_out))
        else $error("read data changed without read");
    a_req_hold: assert property (
        smi_req_out && !io_wr_in && !$past(io_wr_in) &&
        $stable(xt_ctl_bit_in) && $past(xt_ctl_bit_in, 2) == xt_ctl_bit_in
        |=> smi_req_out)
        else $error("smi request dropped without write");
endmodule
bind pm_event_ctrl pm_event_checker #(
    .ADDR_WIDTH(ADDR_WIDTH)
) u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out),
    .wakeup_evt_in(wakeup_evt_in),
    .timer_evt_in(timer_evt_in),
    .xt_ctl_bit_in(xt_ctl_bit_in),
    .smi_req_out(smi_req_out),
    .nmi_req_out(nmi_req_out)
);

// ### testbench.sv
/* Bench for pm_event_ctrl: drives ports on the falling edge, checks
   read-back and requests. Assumes the checker is bound. */
`timescale 1ns/10ps
module testbench;
    reg clk_in = 1'b0, rst_n_in = 1'b0;
    reg [15:0] io_addr_in = 16'h0000;
    reg io_wr_in = 1'b0, io_rd_in = 1'b0;
    reg [7:0] io_wdata_in = 8'h00, card_kbd_evt_in = 8'h00;
    reg ac_power_present_in = 1'b0, battery_low_zero_in = 1'b0;
    reg battery_low_one_in = 1'b0, battery_low_two_in = 1'b0;
    reg suspend_resume_pin_in = 1'b0, gp_pin_evt_in = 1'b0;
    reg serial_rx_pin_in = 1'b1, ring_ind_pin_in = 1'b1;
    reg wakeup_evt_in = 1'b0, alarm_evt_in = 1'b0;
    reg [4:0] timer_evt_in = 5'h00;
    reg xt_mode_in = 1'b0, xt_ctl_bit_in = 1'b0;
    wire [7:0] io_rdata_out, smi_entries, nmi_entries;
    wire smi_req_out, nmi_req_out;
    integer fails = 0, total_checks = 0;
    pm_event_ctrl u_dut (.*);
    core_model u_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .smi_req_in(smi_req_out), .nmi_req_in(nmi_req_out),
        .smi_entries_out(smi_entries), .nmi_entries_out(nmi_entries));
    always #2.5 clk_in = ~clk_in;
    task wt(input integer n);
        repeat (n) @(negedge clk_in);
    endtask
    task chk(input string n, input [7:0] e, input [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task io(input [15:0] a, input [7:0] d);
        io_addr_in = a;
        io_wdata_in = d;
        io_wr_in = 1'b1;
        @(negedge clk_in);
    endtask
    task wr(input [7:0] i, input [7:0] d);
        io(16'h0022, i);
        io(16'h0023, d);
        io_wr_in = 1'b0;
        wt(2);
    endtask
    task rc(input [7:0] i, input [7:0] e);
        io(16'h0022, i);
        io_wr_in = 1'b0;
        io_addr_in = 16'h0023;
        io_rd_in = 1'b1;
        @(negedge clk_in);
        io_rd_in = 1'b0;
        chk($sformatf("reg %h", i), e, io_rdata_out);
    endtask
    task req(input [7:0] s, input [7:0] n);
        chk("smi", s, {7'h00, smi_req_out});
        chk("nmi", n, {7'h00, nmi_req_out});
    endtask
    task t_card;
        integer i;
        wr(8'h91, 8'h1F);
        for (i = 0; i < 8; i = i + 1) begin
            card_kbd_evt_in = 8'h01 << i;
            @(negedge clk_in);
            card_kbd_evt_in = 8'h00;
            wt(3);
            rc(8'h95, (8'h01 << i) & 8'h1F);
            req({7'h00, i < 5}, 8'h00);
            wr(8'h95, 8'h00);
        end
    endtask
    task t_timer;
        integer i;
        wr(8'h92, 8'h15);
        rc(8'h92, 8'h15);
        rc(8'h9F, 8'h00);
        wr(8'h98, 8'h01);
        for (i = 0; i < 6; i = i + 1) begin
            {gp_pin_evt_in, timer_evt_in} = 6'h01 << i;
            @(negedge clk_in);
            {gp_pin_evt_in, timer_evt_in} = 6'h00;
            wt(3);
            rc(8'h96, (8'h01 << i) & 8'h35);
            req(8'h00, (8'h35 >> i) & 8'h01);
            wr(8'h96, 8'h00);
        end
        wr(8'h98, 8'h00);
    endtask
    task t_force;
        wr(8'h90, 8'h81);
        wt(3);
        rc(8'h90, 8'h80);
        rc(8'h94, 8'h01);
        req(8'h01, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h98, 8'h10);
        wakeup_evt_in = 1'b1;
        @(negedge clk_in);
        wakeup_evt_in = 1'b0;
        wt(3);
        wr(8'h90, 8'h12);
        alarm_evt_in = 1'b1;
        @(negedge clk_in);
        alarm_evt_in = 1'b0;
        wt(3);
        rc(8'h94, 8'h92);
        req(8'h01, 8'h01);
        wr(8'h90, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h98, 8'h00);
        req(8'h00, 8'h00);
    endtask
    task t_susp;
        wr(8'h90, 8'h0C);
        wt(3);
        wr(8'h94, 8'h00);
        suspend_resume_pin_in = 1'b1;
        wt(8);
        rc(8'h94, 8'h08);
        suspend_resume_pin_in = 1'b0;
        wt(8);
        wr(8'h94, 8'h04);
        rc(8'h94, 8'h0C);
        req(8'h01, 8'h00);
        wr(8'h90, 8'h00);
        wr(8'h94, 8'h00);
        rc(8'h94, 8'h00);
        req(8'h00, 8'h00);
    endtask
    task t_edge;
        battery_low_zero_in = 1'b1;
        wt(6);
        wr(8'h98, 8'h02);
        wr(8'h93, 8'h03);
        wt(3);
        rc(8'h93, 8'h03);
        rc(8'h97, 8'h02);
        req(8'h00, 8'h01);
        wr(8'h97, 8'h00);
        battery_low_zero_in = 1'b0;
        wt(8);
        wr(8'h97, 8'h02);
        rc(8'h97, 8'h01);
        wr(8'h93, 8'h00);
        wr(8'h97, 8'h00);
        rc(8'h97, 8'h00);
        req(8'h00, 8'h00);
        wr(8'h98, 8'h00);
    endtask
    task t_xt;
        reg [7:0] n0;
        xt_mode_in = 1'b1;
        wr(8'h91, 8'h10);
        n0 = smi_entries;
        card_kbd_evt_in = 8'h10;
        @(negedge clk_in);
        card_kbd_evt_in = 8'h00;
        wt(3);
        wr(8'h95, 8'h00);
        req(8'h01, 8'h00);
        xt_ctl_bit_in = ~xt_ctl_bit_in;
        wt(3);
        req(8'h00, 8'h00);
        chk("smi entries", n0 + 8'h01, smi_entries);
    endtask
    task t_uart;
        reg [7:0] n0;
        n0 = nmi_entries;
        wr(8'h98, 8'h44);
        rc(8'h98, 8'h44);
        wr(8'h90, 8'h60);
        serial_rx_pin_in = 1'b0;
        wt(8);
        rc(8'h94, 8'h40);
        req(8'h00, 8'h01);
        ring_ind_pin_in = 1'b0;
        wt(8);
        wr(8'h93, 8'h40);
        rc(8'h94, 8'h60);
        rc(8'h97, 8'h40);
        @(negedge clk_in);
        io_addr_in = 16'h0022;
        io_rd_in = 1'b1;
        @(negedge clk_in);
        io_rd_in = 1'b0;
        chk("index", 8'h97, io_rdata_out);
        req(8'h01, 8'h01);
        wr(8'h90, 8'h00);
        wr(8'h93, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h97, 8'h00);
        serial_rx_pin_in = 1'b1;
        ring_ind_pin_in = 1'b1;
        wt(8);
        req(8'h00, 8'h00);
        chk("nmi entries", n0 + 8'h01, nmi_entries);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        wt(2);
        rst_n_in = 1'b1;
        wt(6);
        t_card;
        t_timer;
        t_force;
        t_susp;
        t_edge;
        t_xt;
        t_uart;
        test_done;
    end
    initial begin
        wt(20000);
        fails = fails + 1;
        test_done;
    end
endmodule
